// ===== hdl/motion_detect_map.svh
// Purpose: Offsets, field positions, reset values and counts of the motion detect control block.
// Assumes: Register indices are word indices; the byte address is four times the index.
// Notes:   Definitions only.
`ifndef MOTION_DETECT_MAP_SVH
`define MOTION_DETECT_MAP_SVH

`define IDX_STILL_COUNT_HI   8'h25
`define IDX_STILL_COUNT_LO   8'h26
`define IDX_MOTION_CTL       8'h27
`define IDX_FIFO_SETUP       8'h28
`define IDX_EVENT_STATUS     8'h30

`define CTL_MOTION_LSB       0
`define CTL_STILL_LSB        2
`define CTL_CHAIN_LSB        4
`define CTL_WRITE_MASK       8'h3F

`define ST_MOTION_BIT        0
`define ST_STILL_BIT         1
`define ST_AUX_BIT           2
`define ST_PHASE_BIT         3

`define CTL_RESET            8'h00
`define FIFO_RESET           8'h00
`define STILL_COUNT_RESET    16'h0000

`define CHAIN_INDEP          2'h0
`define CHAIN_LINKED         2'h1
`define CHAIN_INDEP_ALT      2'h2
`define CHAIN_LOOP           2'h3

`endif

// ===== hdl/motion_detect_pkg.sv
// Purpose: Types shared by the motion detect control files.
// Assumes: Nothing beyond the map header.
// Notes:   Selector decoding lives here because both detectors use it.
package motion_detect_pkg;

    typedef struct packed {
        logic sample_valid;
        logic above_motion;
        logic below_stillness;
        logic aux_activity;
    } detect_in_t;

    typedef struct packed {
        logic [1:0] chaining_mode;
        logic [1:0] stillness_select;
        logic [1:0] motion_select;
    } detect_ctl_t;

    function automatic logic select_enabled(input logic [1:0] sel);
        return sel[0];
    endfunction

    function automatic logic select_referenced(input logic [1:0] sel);
        return sel == 2'h3;
    endfunction

endpackage

// ===== hdl/stillness_counter.sv
// Purpose: Counts consecutive quiet samples and flags a stillness event.
// Assumes: Samples and compare results arrive on pclk from the comparator logic.
// Notes:   A target of zero behaves like a target of one.
`timescale 1ns/10ps
module stillness_counter
    import motion_detect_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        enable,
    input  wire logic        sample_valid,
    input  wire logic        below,
    input  wire logic [15:0] target,
    output logic             hit
);
    logic [15:0] count_reg;
    logic [16:0] count_plus;

    assign count_plus = {1'b0, count_reg} + 17'h00001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= 16'h0000;
            hit       <= 1'b0;
        end else begin
            hit <= 1'b0;
            if (!enable) begin
                count_reg <= 16'h0000;
            end else if (sample_valid) begin
                if (!below) begin
                    count_reg <= 16'h0000;
                end else if (count_plus >= {1'b0, target}) begin
                    count_reg <= 16'h0000;
                    hit       <= 1'b1;
                end else begin
                    count_reg <= count_plus[15:0];
                end
            end
        end
    end

    still_hit_a: assert property (@(posedge pclk) disable iff (!presetn)
        hit |-> $past(enable && sample_valid && below) && ($past(count_plus) >= {1'b0, $past(target)}))
        else $error("stillness event without a full quiet run");

endmodule // stillness_counter

// ===== hdl/motion_detect_link_control.sv
// Purpose: APB register front end and chaining control of the motion and stillness detectors.
// Assumes: Compare results arrive on pclk with sample_valid; status reads acknowledge held events.
// Notes:   Functional notes follow.
// Functional notes
// - Chaining mode 11 runs one detector at a time, alternating in sequence.
// - Chaining mode 11 acknowledges events internally; no status read needed.
// - Linked or looped modes need both detectors enabled, else independent mode.
// - Chaining only affects x, y, z detection, never auxiliary activity.
// - Stillness select: 00/10 off, 01 absolute, 11 referenced.
// - Motion select: 00/10 off, 01 absolute, 11 referenced.
// - Modes 00 and 10 run both detectors freely; status read clears events.
// - Mode 01 links detectors; each event waits for a status read acknowledgement.
// - Stillness fires after a programmed 16-bit run of quiet samples.
`timescale 1ns/10ps
`include "motion_detect_map.svh"
module motion_detect_link_control
    import motion_detect_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire detect_in_t  detect_in,
    output logic             motion_active,
    output logic             stillness_active,
    output logic             motion_referenced,
    output logic             stillness_referenced,
    output logic             motion_event,
    output logic             stillness_event,
    output logic             aux_event
);
    typedef enum logic [1:0] {WAIT_MOTION, HOLD_MOTION, WAIT_STILL, HOLD_STILL} phase_t;

    detect_ctl_t ctl_reg;
    logic [7:0]  fifo_setup_reg;
    logic [15:0] still_count_reg;
    logic        motion_flag_reg;
    logic        still_flag_reg;
    logic        aux_flag_reg;
    phase_t      phase_reg;
    phase_t      phase_next;

    logic [1:0]  mode_eff;
    logic        motion_en;
    logic        still_en;
    logic        motion_on;
    logic        still_on;
    logic        motion_hit;
    logic        still_hit;
    logic        setup_phase;
    logic        access_done;
    logic        status_read;
    logic [31:0] read_word;
    logic        addr_mapped;

    function automatic logic [11:0] byte_addr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    assign motion_en = select_enabled(ctl_reg.motion_select);
    assign still_en  = select_enabled(ctl_reg.stillness_select);
    // Linking is only meaningful with both detectors on; otherwise run them independently.
    assign mode_eff  = (motion_en && still_en) ? ctl_reg.chaining_mode : `CHAIN_INDEP;
    wire linked_mode = (mode_eff == `CHAIN_LINKED) || (mode_eff == `CHAIN_LOOP);

    assign motion_on  = linked_mode ? (phase_reg == WAIT_MOTION) : motion_en;
    assign still_on   = linked_mode ? (phase_reg == WAIT_STILL) : still_en;
    assign motion_hit = motion_on && detect_in.sample_valid && detect_in.above_motion;

    stillness_counter u_still (
        .pclk         (pclk),
        .presetn      (presetn),
        .enable       (still_on),
        .sample_valid (detect_in.sample_valid),
        .below        (detect_in.below_stillness),
        .target       (still_count_reg),
        .hit          (still_hit)
    );

    // APB: the answer is prepared in the setup cycle so the access phase completes at once.
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready;
    assign status_read = access_done && !pwrite && (paddr == byte_addr(`IDX_EVENT_STATUS));

    always_comb begin
        read_word   = 32'h0000_0000;
        addr_mapped = 1'b1;
        case (paddr)
            byte_addr(`IDX_STILL_COUNT_HI): read_word[7:0] = still_count_reg[15:8];
            byte_addr(`IDX_STILL_COUNT_LO): read_word[7:0] = still_count_reg[7:0];
            byte_addr(`IDX_MOTION_CTL):     read_word[5:0] = ctl_reg;
            byte_addr(`IDX_FIFO_SETUP):     read_word[7:0] = fifo_setup_reg;
            byte_addr(`IDX_EVENT_STATUS): begin
                read_word[`ST_MOTION_BIT] = motion_flag_reg;
                read_word[`ST_STILL_BIT]  = still_flag_reg;
                read_word[`ST_AUX_BIT]    = aux_flag_reg;
                read_word[`ST_PHASE_BIT]  = (phase_reg == WAIT_STILL) || (phase_reg == HOLD_STILL);
            end
            default: addr_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup_phase;
            pslverr <= setup_phase && !addr_mapped;
            if (setup_phase && !pwrite) begin
                prdata <= read_word;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_reg         <= 6'(`CTL_RESET);
            fifo_setup_reg  <= `FIFO_RESET;
            still_count_reg <= `STILL_COUNT_RESET;
        end else if (access_done && pwrite) begin
            case (paddr)
                byte_addr(`IDX_STILL_COUNT_HI): still_count_reg[15:8] <= pwdata[7:0];
                byte_addr(`IDX_STILL_COUNT_LO): still_count_reg[7:0]  <= pwdata[7:0];
                byte_addr(`IDX_MOTION_CTL):     ctl_reg <= pwdata[5:0];
                byte_addr(`IDX_FIFO_SETUP):     fifo_setup_reg <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // In loop mode motion and stillness events are not latched, so the host never has to service the chain.
    // A read clears only the flags it returned, so an event raised during its setup cycle is not lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motion_flag_reg <= 1'b0;
            still_flag_reg  <= 1'b0;
            aux_flag_reg    <= 1'b0;
        end else begin
            if (motion_hit && mode_eff != `CHAIN_LOOP) begin
                motion_flag_reg <= 1'b1;
            end else if (status_read && prdata[`ST_MOTION_BIT]) begin
                motion_flag_reg <= 1'b0;
            end
            if (still_hit && mode_eff != `CHAIN_LOOP) begin
                still_flag_reg <= 1'b1;
            end else if (status_read && prdata[`ST_STILL_BIT]) begin
                still_flag_reg <= 1'b0;
            end
            if (detect_in.sample_valid && detect_in.aux_activity) begin
                aux_flag_reg <= 1'b1;
            end else if (status_read && prdata[`ST_AUX_BIT]) begin
                aux_flag_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        phase_next = phase_reg;
        if (!linked_mode) begin
            phase_next = WAIT_MOTION;
        end else begin
            case (phase_reg)
                WAIT_MOTION: if (motion_hit) begin
                    phase_next = (mode_eff == `CHAIN_LOOP) ? WAIT_STILL : HOLD_MOTION;
                end
                HOLD_MOTION: if ((status_read && prdata[`ST_MOTION_BIT]) || mode_eff == `CHAIN_LOOP) begin
                    phase_next = WAIT_STILL;
                end
                WAIT_STILL: if (still_hit) begin
                    phase_next = (mode_eff == `CHAIN_LOOP) ? WAIT_MOTION : HOLD_STILL;
                end
                HOLD_STILL: if ((status_read && prdata[`ST_STILL_BIT]) || mode_eff == `CHAIN_LOOP) begin
                    phase_next = WAIT_MOTION;
                end
                default: phase_next = WAIT_MOTION;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= WAIT_MOTION;
        end else begin
            phase_reg <= phase_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motion_active        <= 1'b0;
            stillness_active     <= 1'b0;
            motion_referenced    <= 1'b0;
            stillness_referenced <= 1'b0;
            motion_event         <= 1'b0;
            stillness_event      <= 1'b0;
            aux_event            <= 1'b0;
        end else begin
            motion_active        <= motion_on;
            stillness_active     <= still_on;
            motion_referenced    <= select_referenced(ctl_reg.motion_select);
            stillness_referenced <= select_referenced(ctl_reg.stillness_select);
            motion_event         <= motion_hit;
            stillness_event      <= still_hit;
            aux_event            <= detect_in.sample_valid && detect_in.aux_activity;
        end
    end

    loop_one_active_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_eff == `CHAIN_LOOP) |=> !(motion_active && stillness_active))
        else $error("both detectors active in loop mode");
    loop_self_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_eff == `CHAIN_LOOP && motion_hit) |=> !$rose(motion_flag_reg) && phase_reg == WAIT_STILL)
        else $error("loop mode waited for host acknowledge");
    chain_fallback_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(motion_en && still_en) |-> mode_eff == `CHAIN_INDEP)
        else $error("chaining used without both detectors enabled");
    aux_independent_a: assert property (@(posedge pclk) disable iff (!presetn)
        (detect_in.sample_valid && detect_in.aux_activity) |=> aux_flag_reg && aux_event)
        else $error("auxiliary activity lost");
    still_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!ctl_reg.stillness_select[0]) |=> !stillness_active && !stillness_referenced)
        else $error("stillness enabled by a disabling code");
    motion_decode_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ctl_reg.motion_select == 2'h3) |=> motion_referenced)
        else $error("referenced motion not selected");
    flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (motion_flag_reg && !status_read) |=> motion_flag_reg)
        else $error("motion event cleared without status read");
    link_wait_ack_a: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_eff == `CHAIN_LINKED && phase_reg == HOLD_MOTION && !status_read
         && $stable(ctl_reg)) |=> phase_reg == HOLD_MOTION)
        else $error("linked mode moved on without acknowledge");
    ctl_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
        (access_done && !pwrite && paddr == byte_addr(`IDX_MOTION_CTL)) |-> prdata[31:6] == 26'h0)
        else $error("control reserved bits not zero");

endmodule // motion_detect_link_control

// ===== verif/apb_host.sv
// Purpose: APB master that stands in for the host microcontroller.
// Assumes: The slave answers with pready; the bench timeout ends any hang.
// Notes:   Released address and data lines show the inverse of their last value.
`timescale 1ns/10ps
module apb_host (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end

    // The request stays unchanged until the edge that samples pready high.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // apb_host

// ===== verif/testbench.sv
// Purpose: Self-checking bench of the motion detect control block.
// Assumes: Stillness count set to three; the status phase bit is compared only in the chained tests.
// Notes:   Event pulses are counted so checks do not hinge on exact cycles.
`timescale 1ns/10ps
`include "motion_detect_map.svh"
module testbench;
    import motion_detect_pkg::*;
    localparam logic [11:0] A_HI = {2'b00, `IDX_STILL_COUNT_HI, 2'b00};
    localparam logic [11:0] A_LO = {2'b00, `IDX_STILL_COUNT_LO, 2'b00};
    localparam logic [11:0] A_CTL = {2'b00, `IDX_MOTION_CTL, 2'b00};
    localparam logic [11:0] A_FIFO = {2'b00, `IDX_FIFO_SETUP, 2'b00};
    localparam logic [11:0] A_ST = {2'b00, `IDX_EVENT_STATUS, 2'b00};
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    detect_in_t  detect_in;
    logic        motion_active;
    logic        stillness_active;
    logic        motion_referenced;
    logic        stillness_referenced;
    logic        motion_event;
    logic        stillness_event;
    logic        aux_event;
    int          fails;
    int          check_count;
    int          cyc;
    int          mc;
    int          sc;
    int          xc;
    int          m0;
    int          s0;
    logic [31:0] d;
    logic [31:0] r;
    logic        e;
    logic [5:0]  modes [2];

    motion_detect_link_control motion_detect_link_control_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .detect_in(detect_in), .motion_active(motion_active), .stillness_active(stillness_active),
        .motion_referenced(motion_referenced), .stillness_referenced(stillness_referenced),
        .motion_event(motion_event), .stillness_event(stillness_event), .aux_event(aux_event));
    apb_host apb_host_i (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    always #50 pclk = ~pclk;

    always @(posedge pclk) begin
        if (motion_event === 1'b1) mc <= mc + 1;
        if (stillness_event === 1'b1) sc <= sc + 1;
        if (aux_event === 1'b1) xc <= xc + 1;
        cyc <= cyc + 1;
        if (cyc > 5000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] t;
        logic        x;
        apb_host_i.xfer(1'b1, a, v, t, x);
    endtask

    task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] t;
        logic        x;
        apb_host_i.xfer(1'b0, a, 32'h0, t, x);
        chk(t & m, exp);
    endtask

    // One comparator sample; the lines between samples carry noise.
    task automatic send(input logic a, input logic b, input logic x);
        detect_in <= {1'b1, a, b, x};
        @(posedge pclk);
        detect_in <= {1'b0, 3'($urandom)};
        repeat (3) @(posedge pclk);
    endtask

    function automatic logic [31:0] exp_act(input logic [5:0] c);
        logic linked;
        linked = c[0] && c[2] && c[4];
        return {30'h0, c[0], c[2] && !linked};
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        detect_in = '0;
        {fails, check_count, cyc, mc, sc, xc} = '0;
        modes[0] = 6'h05;
        modes[1] = 6'h25;
        d = $urandom(11);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdm(A_CTL, 32'hFFFFFFFF, 32'h0);
        rdm(A_FIFO, 32'hFFFFFFFF, 32'h0);
        rdm(A_HI, 32'hFFFFFFFF, 32'h0);
        chk({30'h0, motion_active, stillness_active}, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            d = $urandom;
            if (i < 16) d[3:0] = i[3:0];
            wr(A_CTL, d);
            rdm(A_CTL, 32'hFFFFFFFF, d & 32'h3F);
            chk({30'h0, motion_active, stillness_active}, exp_act(d[5:0]));
            chk({30'h0, motion_referenced, stillness_referenced}, {30'h0, d[1:0] == 2'h3, d[3:2] == 2'h3});
            d = $urandom;
            wr(A_FIFO, d);
            rdm(A_FIFO, 32'hFFFFFFFF, d & 32'hFF);
        end
        apb_host_i.xfer(1'b0, 12'h004, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        $display("test registers done");
        wr(A_LO, 32'h3);
        foreach (modes[k]) begin
            wr(A_CTL, {26'h0, modes[k]});
            m0 = mc;
            s0 = sc;
            send(1'b1, 1'b0, 1'b0);
            chk(mc, m0 + 1);
            rdm(A_ST, 32'h7, 32'h1);
            rdm(A_ST, 32'h7, 32'h0);
            send(1'b0, 1'b1, 1'b0);
            send(1'b0, 1'b1, 1'b0);
            chk(sc, s0);
            send(1'b0, 1'b1, 1'b0);
            chk(sc, s0 + 1);
            rdm(A_ST, 32'h7, 32'h2);
        end
        $display("test independent done");
        wr(A_CTL, 32'h15);
        m0 = mc;
        s0 = sc;
        send(1'b1, 1'b0, 1'b0);
        chk(mc, m0 + 1);
        chk({30'h0, motion_active, stillness_active}, 32'h0);
        repeat (3) send(1'b0, 1'b1, 1'b0);
        chk(sc, s0);
        rdm(A_ST, 32'hF, 32'h1);
        repeat (3) send(1'b0, 1'b1, 1'b0);
        chk(sc, s0 + 1);
        rdm(A_ST, 32'hF, 32'hA);
        $display("test linked done");
        wr(A_CTL, 32'h35);
        m0 = mc;
        s0 = sc;
        send(1'b1, 1'b0, 1'b0);
        chk(mc, m0 + 1);
        chk({30'h0, motion_active, stillness_active}, 32'h1);
        repeat (3) send(1'b0, 1'b1, 1'b0);
        chk(sc, s0 + 1);
        send(1'b1, 1'b0, 1'b1);
        chk(mc, m0 + 2);
        chk(xc, 1);
        rdm(A_ST, 32'hF, 32'hC);
        $display("test loop done");
        give_verdict();
    end
endmodule // testbench
